/* File: csm_pkg.sv */
// package for the coefficient sign-magnitude store
// assumes a 16-bit word-addressed calibration memory port
package csm_pkg;
    localparam int unsigned WORD_W = 16;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned MAG_W = 17;
    localparam int unsigned NUM_BRIDGE = 7;
    localparam int unsigned NUM_TEMP = 3;
    localparam int unsigned NUM_COEF = 10;
    localparam logic [7:0] ADDR_BRIDGE_HI = 8'h03;
    localparam logic [7:0] ADDR_TEMP_HI = 8'h04;
    localparam logic [7:0] ADDR_OFFSET_B = 8'h05;
    localparam logic [7:0] ADDR_GAIN_B = 8'h06;
    localparam logic [7:0] ADDR_TCG = 8'h07;
    localparam logic [7:0] ADDR_TCO = 8'h08;
    localparam logic [7:0] ADDR_OFFSET_THERMAL_Q = 8'h09;
    localparam logic [7:0] ADDR_SCALE_THERMAL_Q = 8'h0a;
    localparam logic [7:0] ADDR_BRIDGE_Q = 8'h0b;
    localparam logic [7:0] ADDR_OFFSET_T = 8'h0c;
    localparam logic [7:0] ADDR_GAIN_T = 8'h0d;
    localparam logic [7:0] ADDR_TEMP_Q = 8'h0e;
    localparam logic [15:0] HI_RESET = 16'h0000;
    localparam int unsigned BIT_CURVE = 14;
    localparam int unsigned BIT_SETTLING = 15;
    localparam int unsigned TEMP_USED_W = 6;
endpackage : csm_pkg

/* File: csm_coef_join.sv */
// one coefficient assembler: high word pair plus low word
// assumes low word arrives from the calibration word store
`timescale 1ns/1ns
`default_nettype none
module csm_coef_join #(
    parameter int unsigned LOW_W = 16
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic mag_hi_i,
    input wire logic sign_i,
    input wire logic [LOW_W-1:0] low_i,
    output logic [LOW_W:0] mag_o,
    output logic neg_o
);
    // registered sign-magnitude output, zero at reset
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            mag_o <= '0;
            neg_o <= 1'b0;
        end else begin
            mag_o <= {mag_hi_i, low_i};
            neg_o <= sign_i;
        end
    end
endmodule : csm_coef_join
`default_nettype wire

/* File: csm_store.sv */
// Functional notes
// - word 03 bit 0 tops offset magnitude
// - word 03 bit 1 is offset sign
// - word 03 bit 2 tops gain magnitude
// - word 03 bit 3 is gain sign
// - bits 4,5 form thermal gain coefficient
// - bits 6,7 form thermal offset coefficient
// - bits 8,9 form quadratic offset thermal
// - bits 10,11 form quadratic scale thermal
// - bits 12,13 form bridge quadratic coefficient
// - bit 14 picks parabolic or s-curve
// - bit 15 is settling term sign
// - word 04 bits 0,1 temp gain
// - word 04 bits 2,3 temp quadratic
// - word 04 bits 4,5 temp offset
// - sign zero positive, one negative
//
// holds words 03 and 04 and assembles ten coefficients
// assumes low words 05..0e are supplied by the word store
`timescale 1ns/1ns
`default_nettype none
module csm_store #(
    parameter int unsigned WORD_W = csm_pkg::WORD_W,
    parameter int unsigned ADDR_W = csm_pkg::ADDR_W
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic wr_en_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [WORD_W-1:0] wdata_i,
    input wire logic [WORD_W-1:0] offset_b_low_i,
    input wire logic [WORD_W-1:0] gain_b_low_i,
    input wire logic [WORD_W-1:0] tcg_low_i,
    input wire logic [WORD_W-1:0] tco_low_i,
    input wire logic [WORD_W-1:0] offset_thermal_quadratic_low_i,
    input wire logic [WORD_W-1:0] scale_thermal_quadratic_low_i,
    input wire logic [WORD_W-1:0] bridge_quadratic_coef_low_i,
    input wire logic [WORD_W-1:0] gain_t_low_i,
    input wire logic [WORD_W-1:0] temp_quadratic_coef_low_i,
    input wire logic [WORD_W-1:0] offset_t_low_i,
    output logic [WORD_W-1:0] rdata_o,
    output logic rhit_o,
    output logic [csm_pkg::NUM_COEF*(WORD_W+1)-1:0] coef_mag_o,
    output logic [csm_pkg::NUM_COEF-1:0] coef_neg_o,
    output logic curve_shape_select_o,
    output logic settling_term_polarity_o
);
    localparam int unsigned N = csm_pkg::NUM_COEF;
    localparam int unsigned NB = csm_pkg::NUM_BRIDGE;

    logic [WORD_W-1:0] bridge_coef_high_bits;
    logic [WORD_W-1:0] temp_coef_high_bits;
    logic [N*WORD_W-1:0] low_words;
    logic [N-1:0] hi_bits;
    logic [N-1:0] sign_bits;

    // assertions below share this clock and reset
    default clocking cb_chk @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    // stored high words; unassigned bits of word 04 kept as written
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            bridge_coef_high_bits <= csm_pkg::HI_RESET;
            temp_coef_high_bits <= csm_pkg::HI_RESET;
        end else if (wr_en_i) begin
            if (addr_i == ADDR_W'(csm_pkg::ADDR_BRIDGE_HI)) begin
                bridge_coef_high_bits <= wdata_i;
            end
            if (addr_i == ADDR_W'(csm_pkg::ADDR_TEMP_HI)) begin
                temp_coef_high_bits <= wdata_i;
            end
        end
    end

    // read port, registered; other addresses read zero with no hit
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            rdata_o <= '0;
            rhit_o <= 1'b0;
        end else if (addr_i == ADDR_W'(csm_pkg::ADDR_BRIDGE_HI)) begin
            rdata_o <= bridge_coef_high_bits;
            rhit_o <= 1'b1;
        end else if (addr_i == ADDR_W'(csm_pkg::ADDR_TEMP_HI)) begin
            rdata_o <= temp_coef_high_bits;
            rhit_o <= 1'b1;
        end else begin
            rdata_o <= '0;
            rhit_o <= 1'b0;
        end
    end

    // low words in coefficient order: bridge pairs, then temperature
    assign low_words = {offset_t_low_i,
        temp_quadratic_coef_low_i,
        gain_t_low_i,
        bridge_quadratic_coef_low_i,
        scale_thermal_quadratic_low_i,
        offset_thermal_quadratic_low_i,
        tco_low_i,
        tcg_low_i, gain_b_low_i, offset_b_low_i};

    // even bit is magnitude bit 16, odd bit is its sign
    always_comb begin
        hi_bits = '0;
        sign_bits = '0;
        for (int i = 0; i < NB; i++) begin
            hi_bits[i] = bridge_coef_high_bits[2*i];
            sign_bits[i] = bridge_coef_high_bits[2*i+1];
        end
        for (int j = 0; j < csm_pkg::NUM_TEMP; j++) begin
            hi_bits[NB+j] = temp_coef_high_bits[2*j];
            sign_bits[NB+j] = temp_coef_high_bits[2*j+1];
        end
    end

    // one assembler per coefficient
    for (genvar g = 0; g < N; g++) begin : g_join
        csm_coef_join #(.LOW_W(WORD_W)) u_join (
            .clk_i(clk_i),
            .nrst_i(nrst_i),
            .mag_hi_i(hi_bits[g]),
            .sign_i(sign_bits[g]),
            .low_i(low_words[g*WORD_W +: WORD_W]),
            .mag_o(coef_mag_o[g*(WORD_W+1) +: WORD_W+1]),
            .neg_o(coef_neg_o[g])
        );
    end

    // curve mode and settling sign, registered
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            curve_shape_select_o <= 1'b0;
            settling_term_polarity_o <= 1'b0;
        end else begin
            curve_shape_select_o <=
                bridge_coef_high_bits[csm_pkg::BIT_CURVE];
            settling_term_polarity_o <=
                bridge_coef_high_bits[csm_pkg::BIT_SETTLING];
        end
    end

    // offset pair, curve mode, settling sign and temp gain sign follow their stored bits one cycle later
    a_offset_sign: assert property ($past(nrst_i) |->
        coef_neg_o[0] == $past(bridge_coef_high_bits[1]))
        else $error("offset sign mismatch");
    a_offset_mag: assert property ($past(nrst_i) |->
        coef_mag_o[WORD_W] == $past(bridge_coef_high_bits[0]))
        else $error("offset magnitude top bit mismatch");
    a_curve_mode: assert property ($past(nrst_i) |->
        curve_shape_select_o ==
        $past(bridge_coef_high_bits[csm_pkg::BIT_CURVE]))
        else $error("curve select mismatch");
    a_settle_sign: assert property ($past(nrst_i) |->
        settling_term_polarity_o ==
        $past(bridge_coef_high_bits[csm_pkg::BIT_SETTLING]))
        else $error("settling sign mismatch");
    a_temp_gain: assert property ($past(nrst_i) |->
        coef_neg_o[NB] == $past(temp_coef_high_bits[1]))
        else $error("temp gain sign mismatch");

    // write then read of one word reads back two edges later
    sequence s_wr_temp;
        wr_en_i && addr_i == ADDR_W'(csm_pkg::ADDR_TEMP_HI);
    endsequence
    sequence s_at_temp;
        addr_i == ADDR_W'(csm_pkg::ADDR_TEMP_HI);
    endsequence
    sequence s_wr_bridge;
        wr_en_i && addr_i == ADDR_W'(csm_pkg::ADDR_BRIDGE_HI);
    endsequence
    sequence s_at_bridge;
        addr_i == ADDR_W'(csm_pkg::ADDR_BRIDGE_HI);
    endsequence
    a_write_read: assert property (
        s_wr_temp ##1 s_at_temp |=> rdata_o == $past(wdata_i, 2))
        else $error("word 04 readback mismatch");
    a_bridge_readback: assert property (
        s_wr_bridge ##1 s_at_bridge |=> rdata_o == $past(wdata_i, 2))
        else $error("word 03 readback mismatch");

    // a write lands in its word at the next edge
    a_store_bridge: assert property (
        s_wr_bridge |=> bridge_coef_high_bits == $past(wdata_i))
        else $error("word 03 write lost");
    a_store_temp: assert property (
        s_wr_temp |=> temp_coef_high_bits == $past(wdata_i))
        else $error("word 04 write lost");
    // with no write both words hold
    a_words_hold: assert property (
        !wr_en_i |=> $stable(bridge_coef_high_bits) &&
        $stable(temp_coef_high_bits))
        else $error("stored word changed without a write");

    // zero storage and zero low word give zero magnitude
    a_zero_mag: assert property (
        bridge_coef_high_bits == '0 && offset_b_low_i == '0 |=>
        coef_mag_o[WORD_W:0] == '0)
        else $error("zero storage gave nonzero magnitude");
    // bridge gain pair
    a_gain_pair: assert property ($past(nrst_i) |->
        coef_neg_o[1] == $past(bridge_coef_high_bits[3]) &&
        coef_mag_o[2*WORD_W+1] == $past(bridge_coef_high_bits[2]))
        else $error("gain sign or top bit mismatch");
    // signs of all slots follow the stored sign bits
    a_neg_vector: assert property ($past(nrst_i) |->
        coef_neg_o == $past(sign_bits))
        else $error("sign vector mismatch");

    // thermal gain pair, slot 2
    a_tcg_pair: assert property ($past(nrst_i) |->
        coef_neg_o[2] == $past(bridge_coef_high_bits[5]) &&
        coef_mag_o[2*(WORD_W+1)+WORD_W] == $past(bridge_coef_high_bits[4]))
        else $error("thermal gain pair mismatch");
    // thermal offset pair, slot 3
    a_tco_pair: assert property ($past(nrst_i) |->
        coef_neg_o[3] == $past(bridge_coef_high_bits[7]) &&
        coef_mag_o[3*(WORD_W+1)+WORD_W] == $past(bridge_coef_high_bits[6]))
        else $error("thermal offset pair mismatch");
    // quadratic offset thermal pair, slot 4
    a_oq_pair: assert property ($past(nrst_i) |->
        coef_neg_o[4] == $past(bridge_coef_high_bits[9]) &&
        coef_mag_o[4*(WORD_W+1)+WORD_W] == $past(bridge_coef_high_bits[8]))
        else $error("quadratic offset pair mismatch");
    // quadratic scale thermal pair, slot 5
    a_sq_pair: assert property ($past(nrst_i) |->
        coef_neg_o[5] == $past(bridge_coef_high_bits[11]) &&
        coef_mag_o[5*(WORD_W+1)+WORD_W] == $past(bridge_coef_high_bits[10]))
        else $error("quadratic scale pair mismatch");
    // bridge quadratic pair, slot 6
    a_bq_pair: assert property ($past(nrst_i) |->
        coef_neg_o[6] == $past(bridge_coef_high_bits[13]) &&
        coef_mag_o[6*(WORD_W+1)+WORD_W] == $past(bridge_coef_high_bits[12]))
        else $error("bridge quadratic pair mismatch");
    // temperature gain top bit, slot 7
    a_tg_mag: assert property ($past(nrst_i) |->
        coef_mag_o[7*(WORD_W+1)+WORD_W] == $past(temp_coef_high_bits[0]))
        else $error("temp gain top bit mismatch");
    // temperature quadratic pair, slot 8
    a_tq_pair: assert property ($past(nrst_i) |->
        coef_neg_o[8] == $past(temp_coef_high_bits[3]) &&
        coef_mag_o[8*(WORD_W+1)+WORD_W] == $past(temp_coef_high_bits[2]))
        else $error("temp quadratic pair mismatch");
    // temperature offset pair, slot 9
    a_to_pair: assert property ($past(nrst_i) |->
        coef_neg_o[9] == $past(temp_coef_high_bits[5]) &&
        coef_mag_o[9*(WORD_W+1)+WORD_W] == $past(temp_coef_high_bits[4]))
        else $error("temp offset pair mismatch");

    // low magnitude bits come straight from the low words
    a_offset_low: assert property ($past(nrst_i) |->
        coef_mag_o[0 +: WORD_W] == $past(offset_b_low_i))
        else $error("offset low word mismatch");
    // gain low word, slot 1
    a_gain_low: assert property ($past(nrst_i) |->
        coef_mag_o[1*(WORD_W+1) +: WORD_W] == $past(gain_b_low_i))
        else $error("gain low word mismatch");
    // thermal gain low word, slot 2
    a_tcg_low: assert property ($past(nrst_i) |->
        coef_mag_o[2*(WORD_W+1) +: WORD_W] == $past(tcg_low_i))
        else $error("thermal gain low word mismatch");
    // thermal offset low word, slot 3
    a_tco_low: assert property ($past(nrst_i) |->
        coef_mag_o[3*(WORD_W+1) +: WORD_W] == $past(tco_low_i))
        else $error("thermal offset low word mismatch");
    // quadratic offset thermal low word, slot 4
    a_oq_low: assert property ($past(nrst_i) |->
        coef_mag_o[4*(WORD_W+1) +: WORD_W] ==
        $past(offset_thermal_quadratic_low_i))
        else $error("quadratic offset low word mismatch");
    // quadratic scale thermal low word, slot 5
    a_sq_low: assert property ($past(nrst_i) |->
        coef_mag_o[5*(WORD_W+1) +: WORD_W] ==
        $past(scale_thermal_quadratic_low_i))
        else $error("quadratic scale low word mismatch");
    // bridge quadratic low word, slot 6
    a_bq_low: assert property ($past(nrst_i) |->
        coef_mag_o[6*(WORD_W+1) +: WORD_W] ==
        $past(bridge_quadratic_coef_low_i))
        else $error("bridge quadratic low word mismatch");
    // temperature gain low word, slot 7
    a_tg_low: assert property ($past(nrst_i) |->
        coef_mag_o[7*(WORD_W+1) +: WORD_W] == $past(gain_t_low_i))
        else $error("temp gain low word mismatch");
    // temperature quadratic low word, slot 8
    a_tq_low: assert property ($past(nrst_i) |->
        coef_mag_o[8*(WORD_W+1) +: WORD_W] ==
        $past(temp_quadratic_coef_low_i))
        else $error("temp quadratic low word mismatch");
    // temperature offset low word, slot 9
    a_to_low: assert property ($past(nrst_i) |->
        coef_mag_o[9*(WORD_W+1) +: WORD_W] == $past(offset_t_low_i))
        else $error("temp offset low word mismatch");

    // reset clears every output at the edge that sees it
    a_reset_clear: assert property (!$past(nrst_i) |->
        coef_mag_o == '0 && coef_neg_o == '0 && rdata_o == '0 &&
        !rhit_o && !curve_shape_select_o && !settling_term_polarity_o)
        else $error("outputs not clear after reset");

    // other addresses neither hit nor change the stored words
    a_miss_read: assert property (
        addr_i != ADDR_W'(csm_pkg::ADDR_BRIDGE_HI) &&
        addr_i != ADDR_W'(csm_pkg::ADDR_TEMP_HI) |=>
        !rhit_o && rdata_o == '0)
        else $error("unmapped read returned data");
    a_miss_write: assert property (
        wr_en_i && addr_i != ADDR_W'(csm_pkg::ADDR_BRIDGE_HI) &&
        addr_i != ADDR_W'(csm_pkg::ADDR_TEMP_HI) |=>
        $stable(bridge_coef_high_bits) && $stable(temp_coef_high_bits))
        else $error("unmapped write changed a stored word");
    // mapped addresses always hit
    a_hit_read: assert property (
        s_at_bridge or s_at_temp |=> rhit_o)
        else $error("mapped read gave no hit");
endmodule : csm_store
`default_nettype wire

/* File: csm_dsp_model.sv */
// calibration math side model: signs each assembled coefficient
// assumes the store's packed slot layout of 17-bit magnitudes
`timescale 1ns/1ns
`default_nettype none
module csm_dsp_model (
    input wire logic [169:0] mag_i,
    input wire logic [9:0] neg_i,
    output logic [179:0] val_o
);
    logic [17:0] m;
    // sign-magnitude to two's complement, one means negative
    always_comb begin
        for (int k = 0; k < 10; k++) begin
            m = {1'b0, mag_i[k*17 +: 17]};
            val_o[k*18 +: 18] = neg_i[k] ? 18'h0 - m : m;
        end
    end
endmodule : csm_dsp_model
`default_nettype wire

/* File: tb.sv */
// self-checking bench for the coefficient sign-magnitude store
// assumes csm_pkg, csm_store and csm_dsp_model compiled first
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic wr_en_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [15:0] wdata_i = 16'h0000;
    logic [15:0] lows [10];
    logic [15:0] rdata_o;
    logic rhit_o, curve_o, settle_o;
    logic [169:0] mag_o;
    logic [9:0] neg_o;
    logic [179:0] val;
    int errors = 0;
    int n_compared = 0;
    // low words differ per slot so a swapped slot shows
    initial foreach (lows[k]) lows[k] = 16'h0123 + 16'h1111 * 16'(k);
    csm_store csm_store_i (.clk_i(clk_i), .nrst_i(nrst_i),
        .wr_en_i(wr_en_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .offset_b_low_i(lows[0]), .gain_b_low_i(lows[1]),
        .tcg_low_i(lows[2]), .tco_low_i(lows[3]),
        .offset_thermal_quadratic_low_i(lows[4]),
        .scale_thermal_quadratic_low_i(lows[5]),
        .bridge_quadratic_coef_low_i(lows[6]), .gain_t_low_i(lows[7]),
        .temp_quadratic_coef_low_i(lows[8]), .offset_t_low_i(lows[9]),
        .rdata_o(rdata_o), .rhit_o(rhit_o), .coef_mag_o(mag_o),
        .coef_neg_o(neg_o), .curve_shape_select_o(curve_o),
        .settling_term_polarity_o(settle_o));
    csm_dsp_model csm_dsp_model_i (.mag_i(mag_o), .neg_i(neg_o), .val_o(val));
    // clock 50 ns
    initial forever #25 clk_i = ~clk_i;
    task chk(input logic [17:0] got, input logic [17:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [15:0] d);
        wr_en_i = 1'b1;
        addr_i = a;
        wdata_i = d;
        @(posedge clk_i);
        #5;
    endtask : wr
    task rd(input logic [7:0] a, input logic [15:0] d, input logic h);
        wr_en_i = 1'b0;
        addr_i = a;
        @(posedge clk_i);
        #5;
        chk({2'b00, rdata_o}, {2'b00, d});
        chk({17'h0, rhit_o}, {17'h0, h});
    endtask : rd
    task check_all(input logic [15:0] w3, input logic [15:0] w4);
        logic [19:0] hb;
        logic [17:0] m;
        hb = {w4[5:0], w3[13:0]};
        for (int k = 0; k < 10; k++) begin
            m = {1'b0, hb[2*k], lows[k]};
            chk({1'b0, mag_o[k*17 +: 17]}, m);
            chk({17'h0, neg_o[k]}, {17'h0, hb[2*k+1]});
            chk(val[k*18 +: 18], hb[2*k+1] ? 18'h0 - m : m);
        end
        chk({17'h0, curve_o}, {17'h0, w3[14]});
        chk({17'h0, settle_o}, {17'h0, w3[15]});
    endtask : check_all
    task t_walk;
        logic [15:0] p;
        for (int i = 0; i < 32; i++) begin
            p = (i > 15) ? ~(16'h0001 << i[3:0]) : 16'h0001 << i[3:0];
            wr(8'h03, p);
            wr(8'h04, ~p);
            rd(8'h04, ~p, 1'b1);
            check_all(p, ~p);
            rd(8'h03, p, 1'b1);
        end
    endtask : t_walk
    task t_unmapped;
        wr(8'h05, 16'hffff);
        wr(8'h02, 16'hffff);
        rd(8'h05, 16'h0000, 1'b0);
        rd(8'hff, 16'h0000, 1'b0);
        rd(8'h03, 16'h7fff, 1'b1);
        rd(8'h04, 16'h8000, 1'b1);
    endtask : t_unmapped
    task t_rst;
        wr(8'h03, 16'hffff);
        rd(8'h03, 16'hffff, 1'b1);
        rd(8'h03, 16'hffff, 1'b1);
        // zero low words so all-zero storage gives zero magnitudes
        foreach (lows[k]) lows[k] = 16'h0000;
        wr_en_i = 1'b0;
        nrst_i = 1'b0;
        @(posedge clk_i);
        #5;
        chk({1'b0, mag_o[16:0]}, 18'h0);
        nrst_i = 1'b1;
        rd(8'h03, 16'h0000, 1'b1);
        check_all(16'h0000, 16'h0000);
        rd(8'h04, 16'h0000, 1'b1);
    endtask : t_rst
    task print_verdict;
        $display("errors=%0d compared=%0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict
    // watchdog, about thirteen times the expected run
    initial begin
        #100000;
        errors++;
        print_verdict();
    end
    initial begin
        repeat (16) @(posedge clk_i);
        #5;
        nrst_i = 1'b1;
        rd(8'h03, 16'h0000, 1'b1);
        check_all(16'h0000, 16'h0000);
        t_walk();
        t_unmapped();
        t_rst();
        print_verdict();
    end
endmodule : tb
`default_nettype wire
